/* File: hw/sbs_pkg.sv */
// sbs_pkg: shared constants and types for the synchronous burst sram logic.
// assumes one rising-edge core clock shared with the controller.
package sbs_pkg;

    localparam int SBS_ADDR_W = 15;
    localparam int SBS_DATA_W = 32;
    localparam int SBS_LANES = 4;
    localparam int SBS_LANE_W = 8;
    localparam int SBS_WORD_W = 36;
    localparam int SBS_DEPTH = 32768;
    localparam int SBS_BURST_W = 2;
    localparam int SBS_SYNC_STAGES = 2;

    localparam logic [SBS_ADDR_W-1:0] SBS_ADDR_RST = 15'h0000;
    localparam logic [SBS_DATA_W-1:0] SBS_DATA_RST = 32'h0000_0000;
    localparam logic [SBS_LANES-1:0] SBS_LANES_NONE = 4'h0;
    localparam logic [SBS_LANES-1:0] SBS_LANES_ALL = 4'hF;
    localparam logic [SBS_BURST_W-1:0] SBS_BURST_INC = 2'h1;

    // one-hot cycle kind sampled at the last edge
    typedef enum logic [2:0] {
        SBS_IDLE = 3'b001,
        SBS_READ = 3'b010,
        SBS_WRITE = 3'b100
    } sbs_cycle_t;

    // linear burst: low bits wrap inside the four-word group
    function automatic logic [SBS_ADDR_W-1:0] sbs_burst_next(input logic [SBS_ADDR_W-1:0] a);
        sbs_burst_next = {a[SBS_ADDR_W-1:SBS_BURST_W], a[SBS_BURST_W-1:0] + SBS_BURST_INC};
    endfunction

endpackage

/* File: hw/sbs_sram_core.sv */
// sbs_sram_core: cycle logic of a pipelined synchronous burst sram, 32K x 36.
// assumes the controller runs on core_clk; output gate and parity-off pins are
// asynchronous and are resynchronised here.
`timescale 1ns/1ps

// Contract
// - An enabled edge is a read when all lane write enables are high or the processor strobe is low.
// - An enabled edge is a write only when some lane write enable is low and the processor strobe is high.
// - The output gate is ignored, drivers stay off, whenever a write was sampled: a lane write enable low with the processor strobe high.
// - A new external address is loaded at every edge with either strobe low and the chip enabled.
// - While enabled, burst step, write enables and write data are ignored at edges with the processor strobe low.
// - Selection is re-evaluated from the selects only at edges with a strobe low, else it is kept.
// - After a burst starts, each step moves to the next internal burst address, not an external one.
// - The chip is enabled only when both active-low selects are low and the active-high select is high.
// - With parity drive off high, the four parity lane drivers stay off.
// - When deselected the device is in power-down; selected means active.
module sbs_sram_core
    import sbs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [SBS_ADDR_W-1:0] addr,
    input wire logic chip_sel_n,
    input wire logic extra_select_n,
    input wire logic extra_select,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic lane0_write_n,
    input wire logic lane1_write_n,
    input wire logic lane2_write_n,
    input wire logic lane3_write_n,
    input wire logic out_gate_n,
    input wire logic parity_drive_off,
    input wire logic [SBS_DATA_W-1:0] data_in,
    output logic [SBS_DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [SBS_LANES-1:0] parity_lane_in,
    output logic [SBS_LANES-1:0] parity_lane_out,
    output logic [SBS_LANES-1:0] parity_lane_oe,
    output logic powered_down
);

    logic sel_r;
    logic [SBS_ADDR_W-1:0] addr_r;
    logic [SBS_ADDR_W-1:0] addr_nxt;
    sbs_cycle_t cyc_r;
    sbs_cycle_t cyc_nxt;
    logic [SBS_SYNC_STAGES-1:0] gate_sync_r;
    logic [SBS_SYNC_STAGES-1:0] parity_drive_off_sync_r;
    logic gate_n_s;
    logic parity_drive_off_s;
    logic [SBS_LANES-1:0] lane_we_n;
    logic [SBS_LANES-1:0] mem_we;
    logic [SBS_WORD_W-1:0] mem_wdata;
    logic [SBS_WORD_W-1:0] mem_rdata;
    logic strobe_any;
    logic cs_ok;
    logic en_now;
    logic load;
    logic step;
    logic is_wr;

    assign lane_we_n = {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n};
    assign strobe_any = !proc_addr_strobe_n || !ctrl_addr_strobe_n;

    // all three selects sampled alike
    assign cs_ok = !chip_sel_n && !extra_select_n && extra_select;

    // selects only count at strobe edges; otherwise the held state
    assign en_now = strobe_any ? cs_ok : sel_r;

    assign load = strobe_any && cs_ok;

    // a strobe edge reloads when selected and holds otherwise, so step only without one
    assign step = en_now && !strobe_any && !burst_step_n;

    // write needs a low lane and the processor strobe high
    // processor strobe low forces a read whatever the lanes show
    assign is_wr = en_now && (lane_we_n != SBS_LANES_ALL) && proc_addr_strobe_n;

    always_comb begin
        if (load) begin
            addr_nxt = addr;
        end else if (step) begin
            addr_nxt = sbs_burst_next(addr_r);
        end else begin
            addr_nxt = addr_r;
        end
    end

    always_comb begin
        if (!en_now) begin
            cyc_nxt = SBS_IDLE;
        end else if (is_wr) begin
            cyc_nxt = SBS_WRITE;
        end else begin
            cyc_nxt = SBS_READ;
        end
    end

    // pin resynchronisers; only stage two is read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_sync_r <= '1;
            parity_drive_off_sync_r <= '1;
        end else begin
            gate_sync_r <= {gate_sync_r[0], out_gate_n};
            parity_drive_off_sync_r <= {parity_drive_off_sync_r[0], parity_drive_off};
        end
    end
    assign gate_n_s = gate_sync_r[SBS_SYNC_STAGES-1];
    assign parity_drive_off_s = parity_drive_off_sync_r[SBS_SYNC_STAGES-1];

    // selection state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sel_r <= 1'h0;
        end else begin
            sel_r <= en_now;
        end
    end

    // burst address register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_r <= SBS_ADDR_RST;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    // cycle kind of the last edge drives the output turnaround
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cyc_r <= SBS_IDLE;
        end else begin
            case (cyc_r)
                SBS_IDLE,
                SBS_READ,
                SBS_WRITE: begin
                    cyc_r <= cyc_nxt;
                end
                default: begin
                    cyc_r <= SBS_IDLE;
                end
            endcase
        end
    end

    // write lands at the address after load or step, so a step ahead of a
    // write moves it off the loaded word
    assign mem_we = is_wr ? ~lane_we_n : SBS_LANES_NONE;

    always_comb begin
        mem_wdata = '0;
        for (int i = 0; i < SBS_LANES; i++) begin
            mem_wdata[i*(SBS_LANE_W+1) +: SBS_LANE_W+1] = {parity_lane_in[i], data_in[i*SBS_LANE_W +: SBS_LANE_W]};
        end
    end

    sbs_store u_store (
        .core_clk(core_clk),
        .addr(addr_nxt),
        .lane_we(mem_we),
        .wdata(mem_wdata),
        .rdata_r(mem_rdata)
    );

    always_comb begin
        data_out = SBS_DATA_RST;
        parity_lane_out = SBS_LANES_NONE;
        for (int i = 0; i < SBS_LANES; i++) begin
            data_out[i*SBS_LANE_W +: SBS_LANE_W] = mem_rdata[i*(SBS_LANE_W+1) +: SBS_LANE_W];
            parity_lane_out[i] = mem_rdata[i*(SBS_LANE_W+1) + SBS_LANE_W];
        end
    end

    // gate counts only after a read edge; a sampled write keeps drivers off
    // deselect means power-down and no drive
    assign data_oe = (cyc_r == SBS_READ) && !gate_n_s && sel_r;
    assign parity_lane_oe = (data_oe && !parity_drive_off_s) ? SBS_LANES_ALL : SBS_LANES_NONE;
    assign powered_down = !sel_r;

    // nine bits that each lane owns in a stored word
    function automatic logic [SBS_WORD_W-1:0] lane_mask(input logic [SBS_LANES-1:0] lanes);
        lane_mask = '0;
        for (int i = 0; i < SBS_LANES; i++) begin
            lane_mask[i*(SBS_LANE_W+1) +: SBS_LANE_W+1] = {(SBS_LANE_W+1){lanes[i]}};
        end
    endfunction

    // previous edge and whether it wrote, kept so a read of that word at the next edge can be judged lane by lane
    logic chk_wr_r;
    logic [SBS_ADDR_W-1:0] chk_addr_r;
    logic [SBS_WORD_W-1:0] chk_word_r;
    logic [SBS_LANES-1:0] chk_lanes_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chk_wr_r <= 1'h0;
            chk_addr_r <= SBS_ADDR_RST;
            chk_word_r <= '0;
            chk_lanes_r <= SBS_LANES_NONE;
        end else begin
            chk_wr_r <= is_wr;
            chk_addr_r <= addr_nxt;
            chk_word_r <= mem_wdata;
            chk_lanes_r <= mem_we;
        end
    end

    // steps since the last load; every fourth step lands on the loaded word again
    logic [SBS_BURST_W-1:0] chk_steps_r;
    logic [SBS_ADDR_W-1:0] chk_base_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chk_steps_r <= '0;
            chk_base_r <= SBS_ADDR_RST;
        end else if (load) begin
            chk_steps_r <= '0;
            chk_base_r <= addr;
        end else if (step) begin
            chk_steps_r <= chk_steps_r + SBS_BURST_INC;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    proc_read_a: assert property ((en_now && !proc_addr_strobe_n) |=> cyc_r == SBS_READ)
        else $error("processor strobe edge not taken as read");
    write_qual_a: assert property ((en_now && proc_addr_strobe_n && lane_we_n != SBS_LANES_ALL)
        |=> cyc_r == SBS_WRITE && !data_oe)
        else $error("qualified write not taken as write");
    gate_ignored_a: assert property ((cyc_r == SBS_WRITE) |-> !data_oe && parity_lane_oe == SBS_LANES_NONE)
        else $error("output driven after sampled write");
    addr_load_a: assert property (load |=> addr_r == $past(addr))
        else $error("strobe edge did not load address");
    write_capture_a: assert property (is_wr |-> mem_we == ~lane_we_n && mem_we != SBS_LANES_NONE)
        else $error("enabled write not captured");
    sel_hold_a: assert property (!strobe_any |=> sel_r == $past(sel_r))
        else $error("selection changed without strobe");
    burst_step_a: assert property (step
        |=> addr_r[SBS_BURST_W-1:0] == $past(addr_r[SBS_BURST_W-1:0]) + SBS_BURST_INC
        && addr_r[SBS_ADDR_W-1:SBS_BURST_W] == $past(addr_r[SBS_ADDR_W-1:SBS_BURST_W]))
        else $error("burst step wrong");
    burst_wrap_a: assert property ((step && addr_r[SBS_BURST_W-1:0] == 2'h3) |=> addr_r[SBS_BURST_W-1:0] == 2'h0)
        else $error("burst did not wrap in group");
    sel_eval_a: assert property (strobe_any |=> sel_r == $past(cs_ok))
        else $error("selection not from all three selects");
    parity_off_a: assert property (parity_drive_off_s |-> parity_lane_oe == SBS_LANES_NONE)
        else $error("parity lanes driven while disabled");
    pdown_a: assert property ((strobe_any && !cs_ok) |=> powered_down && !data_oe)
        else $error("deselect did not power down");
    lane_only_a: assert property (is_wr |-> (mem_we & lane_we_n) == SBS_LANES_NONE)
        else $error("unselected lane written");

    // same-edge reads return the old word, so the next read of that address shows both halves
    lane_keep_a: assert property ((chk_wr_r && !is_wr && addr_nxt == chk_addr_r)
        |=> ((mem_rdata ^ $past(chk_word_r)) & lane_mask($past(chk_lanes_r))) == '0
        && ((mem_rdata ^ $past(mem_rdata)) & ~lane_mask($past(chk_lanes_r))) == '0)
        else $error("byte lane write disturbed another lane");
    burst_round_a: assert property ((step && chk_steps_r == 2'h3) |=> addr_r == chk_base_r)
        else $error("four burst steps did not return to the loaded word");
    gate_pin_a: assert property (out_gate_n |-> ##2 !data_oe)
        else $error("drivers on with output gate high");
    parity_pin_a: assert property (parity_drive_off |-> ##2 parity_lane_oe == SBS_LANES_NONE)
        else $error("parity lanes driven after parity drive off");
    // the gate pin needs two edges to reach the drivers; reset leaves stage one high
    gate_read_a: assert property ((!$past(rst) && en_now && !is_wr && !$past(out_gate_n)) |=> data_oe)
        else $error("read with output gate low left drivers off");
    pdown_quiet_a: assert property (powered_down |-> !data_oe && parity_lane_oe == SBS_LANES_NONE)
        else $error("drivers on while powered down");
    proc_nowrite_a: assert property (!proc_addr_strobe_n |-> mem_we == SBS_LANES_NONE)
        else $error("processor strobe edge wrote the array");
    read_nowrite_a: assert property ((en_now && !is_wr) |-> mem_we == SBS_LANES_NONE)
        else $error("read edge wrote the array");
    desel_nowrite_a: assert property (!en_now |-> mem_we == SBS_LANES_NONE)
        else $error("deselected edge wrote the array");
    desel_stay_a: assert property ((powered_down && !strobe_any) |=> powered_down)
        else $error("woke without a strobe edge");
    addr_hold_a: assert property ((!load && !step) |=> addr_r == $past(addr_r))
        else $error("address moved without load or step");
    strobe_sel_a: assert property ((strobe_any && cs_ok) |=> !powered_down)
        else $error("selected strobe edge left device powered down");
    parity_pair_a: assert property ((parity_lane_oe != SBS_LANES_NONE) |-> parity_lane_oe == SBS_LANES_ALL && data_oe)
        else $error("parity drivers apart from data drivers");
    cyc_state_a: assert property ($onehot(cyc_r))
        else $error("cycle kind lost its one-hot code");

    // main scenarios

    burst_wrap_c: cover property (load ##1 step [*4]);
    write_then_read_c: cover property ((cyc_r == SBS_WRITE) ##1 (cyc_r == SBS_READ) ##1 data_oe);
    deselect_c: cover property (sel_r ##1 !sel_r);
    lane_write_c: cover property (is_wr && mem_we != SBS_LANES_ALL);
    parity_off_c: cover property (parity_drive_off_s && data_oe);

endmodule

/* File: hw/sbs_store.sv */
// sbs_store: 32K x 36 storage array with four byte lanes of nine bits.
// assumes address and lane enables settle before the core clock edge.
`timescale 1ns/1ps
module sbs_store
    import sbs_pkg::*;
(
    input wire logic core_clk,
    input wire logic [SBS_ADDR_W-1:0] addr,
    input wire logic [SBS_LANES-1:0] lane_we,
    input wire logic [SBS_WORD_W-1:0] wdata,
    output logic [SBS_WORD_W-1:0] rdata_r
);

    localparam int SBS_SLICE_W = SBS_LANE_W + 1;

    logic [SBS_WORD_W-1:0] mem [0:SBS_DEPTH-1];

    // each lane writes only its own nine bits
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < SBS_LANES; i++) begin
            if (lane_we[i]) begin
                mem[addr][i*SBS_SLICE_W +: SBS_SLICE_W] <= wdata[i*SBS_SLICE_W +: SBS_SLICE_W];
            end
        end
    end

    // registered read; a same-edge write returns the old word, never read here
    always_ff @(posedge core_clk) begin
        rdata_r <= mem[addr];
    end

endmodule

/* File: sim/sbs_ctl_model.sv */
// sbs_ctl_model: cache controller model that drives the sram pins at the falling edge.
// assumes the bench calls cyc once per clock and sets rude or parity_drive_off by hierarchy.
`timescale 1ns/1ps
module sbs_ctl_model
    import sbs_pkg::*;
(
    input wire logic core_clk,
    output logic [SBS_ADDR_W-1:0] addr,
    output logic chip_sel_n,
    output logic extra_select_n,
    output logic extra_select,
    output logic proc_addr_strobe_n,
    output logic ctrl_addr_strobe_n,
    output logic burst_step_n,
    output logic [SBS_LANES-1:0] lane_n,
    output logic out_gate_n,
    output logic parity_drive_off,
    output logic [SBS_DATA_W-1:0] data_in,
    output logic [SBS_LANES-1:0] parity_lane_in
);
    logic rude = 1'b0;
    initial begin
        {addr, data_in, parity_lane_in} = '0;
        {chip_sel_n, extra_select_n, extra_select} = 3'h6;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, out_gate_n, parity_drive_off} = 5'h1C;
        lane_n = 4'hF;
    end
    task automatic cyc(input logic ps_n, input logic cs_n, input logic st_n, input logic [2:0] sel,
                       input logic [3:0] ln, input logic [14:0] a, input logic [35:0] w);
        @(negedge core_clk);
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = {ps_n, cs_n, st_n};
        {chip_sel_n, extra_select_n, extra_select} = sel;
        lane_n = ln;
        // address wanders unless a strobe samples it
        addr = (ps_n && cs_n) ? ~addr : a;
        // released data lines do not keep their last value
        {parity_lane_in, data_in} = (ln != 4'hF) ? w : ~{parity_lane_in, data_in};
        out_gate_n = (ln != 4'hF) && !rude;
        @(posedge core_clk);
        #1;
    endtask
endmodule

/* File: sim/sbs_sram_core_tb_top.sv */
// sbs_sram_core_tb_top: self-checking bench for the burst sram cycle logic.
// assumes the controller model drives every pin; bench keeps a reference word store.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h seen %h", n, e, g); end end
module sbs_sram_core_tb_top;
    import sbs_pkg::*;
    localparam logic [2:0] ON = 3'h1;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [SBS_ADDR_W-1:0] addr;
    logic chip_sel_n, extra_select_n, extra_select, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n;
    logic [SBS_LANES-1:0] lane_n, parity_lane_in, parity_lane_out, parity_lane_oe;
    logic out_gate_n, parity_drive_off, data_oe, powered_down;
    logic [SBS_DATA_W-1:0] data_in, data_out;
    logic [SBS_WORD_W-1:0] mem [int];
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    sbs_sram_core dut (.core_clk, .rst, .addr, .chip_sel_n, .extra_select_n, .extra_select, .proc_addr_strobe_n,
        .ctrl_addr_strobe_n, .burst_step_n, .lane0_write_n(lane_n[0]), .lane1_write_n(lane_n[1]),
        .lane2_write_n(lane_n[2]), .lane3_write_n(lane_n[3]), .out_gate_n, .parity_drive_off, .data_in,
        .data_out, .data_oe, .parity_lane_in, .parity_lane_out, .parity_lane_oe, .powered_down);
    sbs_ctl_model ctl (.core_clk, .addr, .chip_sel_n, .extra_select_n, .extra_select, .proc_addr_strobe_n,
        .ctrl_addr_strobe_n, .burst_step_n, .lane_n, .out_gate_n, .parity_drive_off, .data_in, .parity_lane_in);
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            conclude();
        end
    end
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] w, input logic [3:0] ln);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (!ln[i]) begin
                merge[8*i +: 8] = w[8*i +: 8];
                merge[32+i] = w[32+i];
            end
        end
    endfunction
    function automatic logic [14:0] nx(input logic [14:0] a);
        nx = {a[14:2], a[1:0] + 2'h1};
    endfunction
    task automatic wr(input logic [14:0] a, input logic [3:0] ln, input logic [35:0] w);
        ctl.cyc(1'b1, 1'b0, 1'b1, ON, ln, a, w);
        mem[a] = merge(mem.exists(a) ? mem[a] : 36'h0, w, ln);
    endtask
    task automatic rd(input logic [14:0] a);
        ctl.cyc(1'b0, 1'b1, 1'b1, ON, 4'hF, a, 36'h0);
        `CHK("read word", mem[a], {parity_lane_out, data_out})
    endtask
    task automatic idle(input int n);
        repeat (n) ctl.cyc(1'b1, 1'b1, 1'b1, ON, 4'hF, 15'h0, 36'h0);
    endtask
    task automatic t_basic();
        wr(15'h0123, 4'h0, 36'hA_A5A5_5A5A);
        wr(15'h0124, 4'h0, 36'h5_1234_5678);
        rd(15'h0123);
        rd(15'h0124);
        idle(3);
        `CHK("oe on read", 1'b1, data_oe)
        `CHK("active", 1'b0, powered_down)
    endtask
    task automatic t_lanes();
        for (int i = 0; i < 4; i++) begin
            wr(15'h0123, ~(4'h1 << i), 36'h0_0000_0000);
            rd(15'h0123);
        end
        // processor strobe turns a lane-low edge into a read
        ctl.cyc(1'b0, 1'b1, 1'b1, ON, 4'h0, 15'h0124, 36'hF_FFFF_FFFF);
        `CHK("strobe read", mem[15'h0124], {parity_lane_out, data_out})
        rd(15'h0124);
    endtask
    task automatic t_burst();
        logic [14:0] a;
        a = 15'h7FFE;
        wr(a, 4'h0, 36'h1_1111_1111);
        ctl.cyc(1'b1, 1'b1, 1'b1, ON, 4'hB, 15'h0, 36'h0_00C3_0000);
        mem[a] = merge(mem[a], 36'h0_00C3_0000, 4'hB);
        for (int k = 0; k < 3; k++) begin
            a = nx(a);
            ctl.cyc(1'b1, 1'b1, 1'b0, ON, 4'h0, 15'h0, 36'h2_2222_0000 | 36'(k));
            mem[a] = 36'h2_2222_0000 | 36'(k);
        end
        rd(15'h7FFE);
        a = 15'h7FFE;
        for (int k = 0; k < 4; k++) begin
            a = nx(a);
            ctl.cyc(1'b1, 1'b1, 1'b0, ON, 4'hF, 15'h0, 36'h0);
            `CHK("burst read", mem[a], {parity_lane_out, data_out})
        end
        idle(1);
        `CHK("held read", mem[a], {parity_lane_out, data_out})
    endtask
    task automatic t_gate();
        ctl.rude = 1'b1;
        idle(3);
        wr(15'h0050, 4'h0, 36'h3_0BAD_F00D);
        `CHK("oe in write", 1'b0, data_oe)
        ctl.rude = 1'b0;
        rd(15'h0050);
    endtask
    task automatic t_desel();
        logic [2:0] off [3] = '{3'h5, 3'h3, 3'h0};
        for (int i = 0; i < 3; i++) begin
            ctl.cyc(1'b0, 1'b1, 1'b1, off[i], 4'hF, 15'h0123, 36'h0);
            `CHK("power-down", 1'b1, powered_down)
            `CHK("oe off", 1'b0, data_oe)
            // no strobe: selection kept off, write ignored
            ctl.cyc(1'b1, 1'b1, 1'b1, ON, 4'h0, 15'h0123, 36'hE_EEEE_EEEE);
            `CHK("still down", 1'b1, powered_down)
            rd(15'h0123);
        end
    endtask
    task automatic t_depth();
        // one part of a doubled-depth pair: the top address line feeds either its active-high
        // select or its active-low second select, so it plays each half in turn
        for (int top = 0; top < 2; top++) begin
            ctl.cyc(1'b0, 1'b1, 1'b1, {2'h0, top[0]}, 4'hF, 15'h0123, 36'h0);
            `CHK("upper half", !top[0], powered_down)
            ctl.cyc(1'b0, 1'b1, 1'b1, {1'h0, top[0], 1'h1}, 4'hF, 15'h0123, 36'h0);
            `CHK("lower half", top[0], powered_down)
        end
        rd(15'h0123);
    endtask
    task automatic t_parity();
        @(negedge core_clk) ctl.parity_drive_off = 1'b1;
        idle(4);
        `CHK("parity off", 4'h0, parity_lane_oe)
        `CHK("data on", 1'b1, data_oe)
        @(negedge core_clk) ctl.parity_drive_off = 1'b0;
        idle(4);
        `CHK("parity on", 4'hF, parity_lane_oe)
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        `CHK("reset down", 1'b1, powered_down)
        t_basic();
        t_lanes();
        t_burst();
        t_gate();
        t_desel();
        t_depth();
        t_parity();
        conclude();
    end
endmodule
